// >>> design/motion_glue_pkg.sv
// Shared constants for the motion board bus glue.
package motion_glue_pkg;
  // Bus widths
  localparam int ADDR_HI_W   = 8;                        // High address port width
  localparam int PORT_W      = 8;                        // Multiplexed low port width
  localparam int ADDR_W      = ADDR_HI_W + PORT_W;        // Full address width
  localparam int CMD_W       = 5;                        // Host command lines
  localparam int SEL_W       = 3;                        // Motor drive selects
  localparam int TENS_W      = 8;                        // Tension counter width
  // Decoded addresses of the external ports
  localparam logic [15:0] OUT0_ADDR    = 16'h1000;       // First output register
  localparam logic [15:0] OUT1_ADDR    = 16'h1001;       // Second output register
  localparam logic [15:0] TENSION_ADDR = 16'h1002;       // Tension holding register
  // Field positions and reset values
  localparam int          HUB_LOCK_BIT = 4;              // Reel hub latch control bit
  localparam logic [7:0]  OUT_RST      = 8'h00;          // Output registers at reset
  // Timing: crystal 8 MHz, bus clock 2 MHz
  localparam int          XTAL_MHZ     = 8;              // Reference rate
  localparam int          BUS_MHZ      = 2;              // Derived bus clock rate
  localparam int          CLK_DIV      = XTAL_MHZ / BUS_MHZ;  // Divide ratio
  localparam logic [1:0]  DIV_LAST     = 2'(CLK_DIV - 1);     // Terminal count
  localparam logic [1:0]  DIV_HALF     = 2'(CLK_DIV / 2);     // High phase start
endpackage : motion_glue_pkg

// >>> design/bus_decode_if.sv
// Decoded address and strobes passed from the decoder to the glue top.
`timescale 1ns/100ps
interface bus_decode_if;
  logic [15:0] addr_full;                     // Assembled address
  logic        out_reg0_write_strobe_n;       // First output register strobe
  logic        out_reg1_write_strobe_n;       // Second output register strobe
  logic        tension_read_strobe_n;         // Tension holding register strobe
  modport dec  (output addr_full, out_reg0_write_strobe_n, out_reg1_write_strobe_n,
                output tension_read_strobe_n);
  modport user (input addr_full, out_reg0_write_strobe_n, out_reg1_write_strobe_n,
                input tension_read_strobe_n);
endinterface : bus_decode_if

// >>> design/addr_latch_decode.sv
// Low address latch and address decoder for the multiplexed bus.
`timescale 1ns/100ps
module addr_latch_decode
  import motion_glue_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               sys_rst_i,
  // Synchronised processor pins
  input  wire logic [7:0]         addr_hi_i,
  input  wire logic [7:0]         low_port_i,
  input  wire logic               addr_phase_strobe_i,
  input  wire logic               rw_i,
  // Decoded results
  bus_decode_if.dec               dec
);
  logic [7:0] addr_lo_reg;                    // Held low address byte
  logic [7:0] addr_lo_next;
  logic [7:0] addr_lo;                        // Transparent latch output
  logic [2:0] strb_reg;                       // Active-low strobes
  logic [2:0] strb_next;

  // Match of assembled address against one decode slot
  function automatic logic hit(input logic [15:0] a, input logic [15:0] slot);
    return a == slot;
  endfunction : hit

  // Transparent while the strobe is high, holds after it falls
  always_comb
  begin
    addr_lo_next = addr_phase_strobe_i ? low_port_i : addr_lo_reg;  // [R3]
    addr_lo      = addr_phase_strobe_i ? low_port_i : addr_lo_reg;  // [R3]
  end

  // Strobes only in the data phase, so address bytes never fire them
  always_comb
  begin
    strb_next = 3'b111;
    if (!addr_phase_strobe_i)
    begin
      strb_next[0] = !(hit({addr_hi_i, addr_lo}, OUT0_ADDR) && !rw_i);     // [R5]
      strb_next[1] = !(hit({addr_hi_i, addr_lo}, OUT1_ADDR) && !rw_i);     // [R5]
      strb_next[2] = !(hit({addr_hi_i, addr_lo}, TENSION_ADDR) && rw_i);   // [R7]
    end
  end

  // Register the latch and strobes
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      addr_lo_reg <= 8'h00;
      strb_reg    <= 3'b111;
    end
    else
    begin
      addr_lo_reg <= addr_lo_next;
      strb_reg    <= strb_next;
    end
  end

  // High port supplies the upper byte, latch the lower
  assign dec.addr_full               = {addr_hi_i, addr_lo_reg};  // [R1]
  assign dec.out_reg0_write_strobe_n = strb_reg[0];
  assign dec.out_reg1_write_strobe_n = strb_reg[1];
  assign dec.tension_read_strobe_n   = strb_reg[2];

  property p_lo_pass;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    addr_phase_strobe_i |=> addr_lo_reg == $past(low_port_i);
  endproperty
  a_lo_pass: assert property (p_lo_pass) else $error("low latch not transparent"); // [R3]

  property p_lo_hold;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !addr_phase_strobe_i |=> $stable(addr_lo_reg);
  endproperty
  a_lo_hold: assert property (p_lo_hold) else $error("low latch not holding"); // [R3]

  property p_wr0_cause;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(dec.out_reg0_write_strobe_n) |->
      $past(!rw_i) && $past(!addr_phase_strobe_i) && dec.addr_full == OUT0_ADDR;
  endproperty
  a_wr0_cause: assert property (p_wr0_cause) else $error("bad write strobe"); // [R5]

  // Read strobe only for a read at the full assembled tension address
  property p_rd_cause;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(dec.tension_read_strobe_n) |->
      $past(rw_i) && $past(!addr_phase_strobe_i) && dec.addr_full == TENSION_ADDR;
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("bad read strobe"); // [R1] [R7]
endmodule : addr_latch_decode

// >>> design/motion_board_bus_glue.sv
// Glue logic around the motion processor: bus demux, decode, ports, clock.
// Operation
// R1: Address high byte plus latched low byte
// R2: Low port doubles as data; strobe marks phases
// R3: Latch passes while strobe high, holds after
// R4: Divide reference by four for bus clock
// R5: Write strobes decoded per register, write only
// R6: First write strobe loads register; bit4 hub
// R7: Read strobe captures tension counts, drives bus
// R8: Serial lines always enabled, fixed baud rate
// R9: Motor words go out with controller select
// R10: Go strobe captures five host command lines
// R11: Busy to host from executive-controlled flop
// R12: Speed reached signalled toward executive processor
// R13: Output registers clear on reset
`timescale 1ns/100ps
module motion_board_bus_glue
  import motion_glue_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   sys_rst_i,
  // Processor multiplexed bus
  input  wire logic [ADDR_HI_W-1:0]   addr_hi_i,
  input  wire logic [PORT_W-1:0]      low_port_i,
  output logic      [PORT_W-1:0]      low_port_o,
  output logic                        low_port_oe_n_o,
  input  wire logic                   addr_phase_strobe_i,
  input  wire logic                   rw_i,
  output logic                        bus_clock_out_o,
  // External ports
  output logic      [7:0]             out_reg0_o,
  output logic      [7:0]             out_reg1_o,
  output logic                        hub_lock_o,
  input  wire logic [TENS_W-1:0]      tension_count_i,
  // Serial lines between processors
  input  wire logic                   motion_txd_i,
  output logic                        exec_rxd_o,
  input  wire logic                   exec_txd_i,
  output logic                        motion_rxd_o,
  // Motor drive synchronous link
  input  wire logic                   motor_sck_i,
  input  wire logic                   motor_mosi_i,
  input  wire logic [SEL_W-1:0]       motor_sel_n_i,
  output logic                        motor_sck_o,
  output logic                        motor_mosi_o,
  output logic      [SEL_W-1:0]       motor_sel_n_o,
  // Host command and status
  input  wire logic [CMD_W-1:0]       host_cmd_i,
  input  wire logic                   host_go_strobe_i,
  output logic      [CMD_W-1:0]       host_cmd_buf_o,
  input  wire logic                   busy_set_i,
  input  wire logic                   busy_clr_i,
  output logic                        host_busy_flag_o,
  input  wire logic                   speed_ok_i,
  output logic                        speed_reached_o
);
  import motion_glue_pkg::*;

  localparam int SW = ADDR_HI_W + PORT_W + TENS_W + SEL_W + CMD_W + 10;  // Synced pin count
  // All pins but clock and reset come from other chips, so every one crosses two flops
  logic [SW-1:0] sync1_reg;                   // First stage, read only by second
  logic [SW-1:0] sync2_reg;                   // Second stage, safe to use
  logic [7:0]    s_hi, s_port;
  logic [TENS_W-1:0] s_tens;
  logic [SEL_W-1:0]  s_sel;
  logic [CMD_W-1:0]  s_cmd;
  logic s_as, s_rw, s_txm, s_txe, s_sck, s_mosi, s_go, s_bset, s_bclr, s_spd;

  always_ff @(posedge sys_clk_i)
  begin
    sync1_reg <= {addr_hi_i, low_port_i, tension_count_i, motor_sel_n_i, host_cmd_i,
                  addr_phase_strobe_i, rw_i, motion_txd_i, exec_txd_i, motor_sck_i,
                  motor_mosi_i, host_go_strobe_i, busy_set_i, busy_clr_i, speed_ok_i};
    sync2_reg <= sync1_reg;
  end
  // Unpack in the same order as packed, widths match exactly
  assign {s_hi, s_port, s_tens, s_sel, s_cmd, s_as, s_rw, s_txm, s_txe, s_sck, s_mosi,
          s_go, s_bset, s_bclr, s_spd} = sync2_reg;

  // Address latch and decoder
  bus_decode_if dif ();
  addr_latch_decode u_dec (
    .sys_clk_i           (sys_clk_i),
    .sys_rst_i           (sys_rst_i),
    .addr_hi_i           (s_hi),
    .low_port_i          (s_port),
    .addr_phase_strobe_i (s_as),
    .rw_i                (s_rw),
    .dec                 (dif.dec)
  );

  // Divider state and port registers
  logic [1:0] div_reg, div_next;              // Reference divider
  logic       bclk_reg, bclk_next;            // Bus clock output
  logic [7:0] out0_reg, out0_next;            // First output register
  logic [7:0] out1_reg, out1_next;            // Second output register
  logic [7:0] tens_reg, tens_next;            // Tension holding register
  logic       oe_n_reg, oe_n_next;            // Low port drive enable
  logic [2:0] strb_d_reg;                     // Strobes one cycle ago
  logic [CMD_W-1:0] cmd_reg, cmd_next;        // Host command buffer
  logic       go_d_reg;                       // Go strobe one cycle ago
  logic       busy_reg, busy_next;            // Busy flop toward host
  logic       spd_reg, spd_next;              // Speed reached flag
  logic       ser_m_reg, ser_e_reg;           // Serial pass-through flops
  logic       sck_reg, mosi_reg;              // Motor link data and clock
  logic [SEL_W-1:0] sel_reg;                  // Motor controller selects
  logic       wr0_fall, wr1_fall, rd_fall;

  assign wr0_fall = strb_d_reg[0] && !dif.out_reg0_write_strobe_n;
  assign wr1_fall = strb_d_reg[1] && !dif.out_reg1_write_strobe_n;
  assign rd_fall  = strb_d_reg[2] && !dif.tension_read_strobe_n;

  // Next-state logic for every port and flag except the serial and motor pass-throughs
  always_comb
  begin
    // Square wave, high for the second half of each divide cycle
    div_next  = (div_reg == DIV_LAST) ? 2'b00 : div_reg + 2'b01;          // [R4]
    bclk_next = (div_next >= DIV_HALF);                                   // [R4]
    // Data phase byte, or the tension count for a read, is loaded on the strobe's falling edge
    out0_next = wr0_fall ? s_port : out0_reg;                             // [R6]
    out1_next = wr1_fall ? s_port : out1_reg;                             // [R5]
    tens_next = rd_fall  ? s_tens : tens_reg;                             // [R7]
    // Drive the shared port only during the read data phase
    oe_n_next = dif.tension_read_strobe_n;                                // [R2] [R7]
    cmd_next  = (s_go && !go_d_reg) ? s_cmd : cmd_reg;                    // [R10]
    // Set wins over clear so a late set is not lost
    busy_next = s_bset ? 1'b1 : (s_bclr ? 1'b0 : busy_reg);               // [R11]
    spd_next  = s_spd;                                                    // [R12]
  end

  // Registers
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      div_reg    <= 2'b00;
      bclk_reg   <= 1'b0;
      out0_reg   <= OUT_RST;                                              // [R13]
      out1_reg   <= OUT_RST;                                              // [R13]
      tens_reg   <= 8'h00;
      oe_n_reg   <= 1'b1;
      strb_d_reg <= 3'b111;
      cmd_reg    <= '0;
      go_d_reg   <= 1'b0;
      busy_reg   <= 1'b0;
      spd_reg    <= 1'b0;
      ser_m_reg  <= 1'b1;
      ser_e_reg  <= 1'b1;
      sck_reg    <= 1'b0;
      mosi_reg   <= 1'b0;
      sel_reg    <= '1;
    end
    else
    begin
      div_reg    <= div_next;
      bclk_reg   <= bclk_next;
      out0_reg   <= out0_next;
      out1_reg   <= out1_next;
      tens_reg   <= tens_next;
      oe_n_reg   <= oe_n_next;
      strb_d_reg <= {dif.tension_read_strobe_n, dif.out_reg1_write_strobe_n,
                     dif.out_reg0_write_strobe_n};
      cmd_reg    <= cmd_next;
      go_d_reg   <= s_go;
      busy_reg   <= busy_next;
      spd_reg    <= spd_next;
      // No gating: the serial path is always open
      ser_m_reg  <= s_txm;                                                // [R8]
      ser_e_reg  <= s_txe;                                                // [R8]
      // Select moves in the same cycle as clock and data
      sck_reg    <= s_sck;                                                // [R9]
      mosi_reg   <= s_mosi;                                               // [R9]
      sel_reg    <= s_sel;                                                // [R9]
    end
  end

  // Outputs straight from flops
  assign bus_clock_out_o  = bclk_reg;
  assign out_reg0_o       = out0_reg;
  assign out_reg1_o       = out1_reg;
  assign hub_lock_o       = out0_reg[HUB_LOCK_BIT];                       // [R6]
  assign low_port_o       = tens_reg;
  assign low_port_oe_n_o  = oe_n_reg;
  assign exec_rxd_o       = ser_m_reg;
  assign motion_rxd_o     = ser_e_reg;
  assign motor_sck_o      = sck_reg;
  assign motor_mosi_o     = mosi_reg;
  assign motor_sel_n_o    = sel_reg;
  assign host_cmd_buf_o   = cmd_reg;
  assign host_busy_flag_o = busy_reg;
  assign speed_reached_o  = spd_reg;

  property p_bclk_period;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(bclk_reg) |-> ##4 $rose(bclk_reg);
  endproperty
  a_bclk_period: assert property (p_bclk_period) else $error("bus clock not /4"); // [R4]

  property p_out0_load;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(dif.out_reg0_write_strobe_n) |=> out0_reg == $past(s_port);
  endproperty
  a_out0_load: assert property (p_out0_load) else $error("reg0 not loaded"); // [R6]

  property p_tens_cap;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(dif.tension_read_strobe_n) |=> tens_reg == $past(s_tens) && !low_port_oe_n_o;
  endproperty
  a_tens_cap: assert property (p_tens_cap) else $error("tension not captured"); // [R7]

  property p_drive_read;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !low_port_oe_n_o |-> $past(!dif.tension_read_strobe_n);
  endproperty
  a_drive_read: assert property (p_drive_read) else $error("port driven off read"); // [R2]

  property p_cmd_cap;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_go && !go_d_reg) |=> host_cmd_buf_o == $past(s_cmd);
  endproperty
  a_cmd_cap: assert property (p_cmd_cap) else $error("command not buffered"); // [R10]

  property p_busy;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_bset |=> host_busy_flag_o ##1 (host_busy_flag_o || $past(s_bclr && !s_bset));
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set"); // [R11]

  property p_speed;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(speed_ok_i) |-> ##3 speed_reached_o;
  endproperty
  a_speed: assert property (p_speed) else $error("speed reached late"); // [R12]

  property p_reset_clear;
    @(posedge sys_clk_i)
    sys_rst_i |=> out0_reg == OUT_RST && out1_reg == OUT_RST && !hub_lock_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared"); // [R13]
endmodule : motion_board_bus_glue

// >>> tb/motion_cpu_model.sv
// Behavioural model of the motion processor driving the multiplexed bus.
`timescale 1ns/100ps
module motion_cpu_model
  import motion_glue_pkg::*;
(
  // Clock
  input  wire logic                 sys_clk_i,
  // Bus pins toward the glue
  output logic      [ADDR_HI_W-1:0] addr_hi_o,
  output wire logic [PORT_W-1:0]    low_port_o,
  output logic                      addr_phase_strobe_o,
  output logic                      rw_o,
  // Glue drive of the shared port
  input  wire logic [PORT_W-1:0]    dut_port_i,
  input  wire logic                 dut_oe_n_i
);
  logic [PORT_W-1:0] cpu_val;    // Value the processor puts on the port
  logic              cpu_drive;  // Processor drives the port
  logic [PORT_W-1:0] last_val = '0;  // Last settled level on the port

  // Released port toggles, so a stale value can never pass as a read
  assign low_port_o = !dut_oe_n_i ? dut_port_i : (cpu_drive ? cpu_val : ~last_val);

  // Remember the wire level for the release pattern
  always @(posedge sys_clk_i)
    last_val <= low_port_o;

  // Idle: address phase, port released
  initial
  begin
    addr_hi_o           = 8'h00;
    addr_phase_strobe_o = 1'b1;
    rw_o                = 1'b1;
    cpu_drive           = 1'b0;
    cpu_val             = 8'h00;
  end

  // Pins move a fixed delay after the rising edge
  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask : step

  // Address phase: high byte on its port, low byte on the shared port
  task automatic addr_phase(input logic [15:0] addr, input logic rd);
    addr_hi_o           = addr[15:8];
    cpu_val             = addr[7:0];
    cpu_drive           = 1'b1;
    rw_o                = rd;
    addr_phase_strobe_o = 1'b1;
    step(3);
  endtask : addr_phase

  // Write: data replaces the address once the strobe drops
  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    addr_phase(addr, 1'b0);
    addr_phase_strobe_o = 1'b0;
    cpu_val             = data;
    step(6);
    addr_phase_strobe_o = 1'b1;
    cpu_drive           = 1'b0;
    step(2);
  endtask : wr

  // Read: port turned round, value taken late in the data phase
  task automatic rd(input logic [15:0] addr, output logic [7:0] data, output logic oe_n);
    addr_phase(addr, 1'b1);
    addr_phase_strobe_o = 1'b0;
    cpu_drive           = 1'b0;
    step(6);
    data                = low_port_o;
    oe_n                = dut_oe_n_i;
    addr_phase_strobe_o = 1'b1;
    step(6);
  endtask : rd
endmodule : motion_cpu_model

// >>> tb/tb_top.sv
// Self-checking bench for the motion board bus glue.
`timescale 1ns/100ps
module tb_top;
  import motion_glue_pkg::*;
  typedef struct packed {logic [15:0] addr; logic [7:0] data; logic [7:0] e0; logic [7:0] e1;} row_t;
  localparam int TIMEOUT = 5000;  // Whole run needs well under this
  logic              sys_clk_i = 1'b0;
  logic              sys_rst_i;
  logic [7:0]        addr_hi, low_port_i, low_port_o, out_reg0_o, out_reg1_o, tension_count_i;
  logic              low_port_oe_n_o, strobe, rw, bus_clock_out_o, hub_lock_o;
  logic              motion_txd_i, exec_rxd_o, exec_txd_i, motion_rxd_o;
  logic              motor_sck_i, motor_mosi_i, motor_sck_o, motor_mosi_o;
  logic [SEL_W-1:0]  motor_sel_n_i, motor_sel_n_o;
  logic [CMD_W-1:0]  host_cmd_i, host_cmd_buf_o;
  logic              host_go_strobe_i, busy_set_i, busy_clr_i, host_busy_flag_o;
  logic              speed_ok_i, speed_reached_o, rd_oe_n;
  logic [7:0]        rd_data;
  logic [7:0]        bc;          // Bus clock samples
  int                miscompares, samples_checked, cycles;
  // Writes with expected register images; unmapped and read-only places left alone
  row_t rows [7] = '{
    '{16'h1000, 8'h10, 8'h10, 8'h00}, '{16'h1001, 8'hA5, 8'h10, 8'hA5},
    '{16'h1000, 8'hEF, 8'hEF, 8'hA5}, '{16'h1002, 8'h33, 8'hEF, 8'hA5},
    '{16'h1100, 8'h55, 8'hEF, 8'hA5}, '{16'h1003, 8'h77, 8'hEF, 8'hA5},
    '{16'h1000, 8'h00, 8'h00, 8'hA5}};

  always #5 sys_clk_i = ~sys_clk_i;

  motion_board_bus_glue motion_board_bus_glue_i (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_hi_i(addr_hi),
    .low_port_i(low_port_i), .low_port_o(low_port_o), .low_port_oe_n_o(low_port_oe_n_o),
    .addr_phase_strobe_i(strobe), .rw_i(rw), .bus_clock_out_o(bus_clock_out_o),
    .out_reg0_o(out_reg0_o), .out_reg1_o(out_reg1_o), .hub_lock_o(hub_lock_o),
    .tension_count_i(tension_count_i), .motion_txd_i(motion_txd_i), .exec_rxd_o(exec_rxd_o),
    .exec_txd_i(exec_txd_i), .motion_rxd_o(motion_rxd_o), .motor_sck_i(motor_sck_i),
    .motor_mosi_i(motor_mosi_i), .motor_sel_n_i(motor_sel_n_i), .motor_sck_o(motor_sck_o),
    .motor_mosi_o(motor_mosi_o), .motor_sel_n_o(motor_sel_n_o), .host_cmd_i(host_cmd_i),
    .host_go_strobe_i(host_go_strobe_i), .host_cmd_buf_o(host_cmd_buf_o),
    .busy_set_i(busy_set_i), .busy_clr_i(busy_clr_i), .host_busy_flag_o(host_busy_flag_o),
    .speed_ok_i(speed_ok_i), .speed_reached_o(speed_reached_o));

  motion_cpu_model motion_cpu_model_i (
    .sys_clk_i(sys_clk_i), .addr_hi_o(addr_hi), .low_port_o(low_port_i),
    .addr_phase_strobe_o(strobe), .rw_o(rw), .dut_port_i(low_port_o),
    .dut_oe_n_i(low_port_oe_n_o));

  // Byte compare; narrower values are zero extended by the caller
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_byte

  // Single-bit compare
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask : chk_bit

  // Counts, verdict and end of run
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // Hang guard
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == TIMEOUT)
    begin
      miscompares++;
      final_report();
    end
  end

  // Output registers and other state at their reset images
  task automatic chk_reset();
    chk_byte(out_reg0_o, 8'h00, "reg0 reset");
    chk_byte(out_reg1_o, 8'h00, "reg1 reset");
    chk_bit(hub_lock_o, 1'b0, "hub reset");
    chk_bit(low_port_oe_n_o, 1'b1, "port drive reset");
    chk_byte({3'h0, host_cmd_buf_o}, 8'h00, "cmd reset");
    chk_bit(host_busy_flag_o, 1'b0, "busy reset");
  endtask : chk_reset

  initial
  begin
    sys_rst_i = 1'b1;
    {motion_txd_i, exec_txd_i, motor_sel_n_i} = 5'h1F;
    {motor_sck_i, motor_mosi_i, host_go_strobe_i, busy_set_i, busy_clr_i, speed_ok_i} = 6'h00;
    host_cmd_i      = 5'h00;
    tension_count_i = 8'h5A;
    motion_cpu_model_i.step(20);
    chk_reset();
    chk_byte({5'h00, motor_sel_n_o}, 8'h07, "select reset");
    chk_bit(exec_rxd_o, 1'b1, "serial idle");
    sys_rst_i = 1'b0;
    motion_cpu_model_i.step(3);
    // Ordinary writes, one row each
    foreach (rows[i])
    begin
      motion_cpu_model_i.wr(rows[i].addr, rows[i].data);
      chk_byte(out_reg0_o, rows[i].e0, "reg0");
      chk_byte(out_reg1_o, rows[i].e1, "reg1");
      chk_bit(hub_lock_o, rows[i].e0[HUB_LOCK_BIT], "hub lock");
    end
    // Tension read drives the port; read at an output address does not
    motion_cpu_model_i.rd(TENSION_ADDR, rd_data, rd_oe_n);
    chk_byte(rd_data, 8'h5A, "tension read");
    chk_bit(rd_oe_n, 1'b0, "read drive");
    chk_bit(low_port_oe_n_o, 1'b1, "drive released");
    tension_count_i = 8'hC3;
    motion_cpu_model_i.rd(OUT1_ADDR, rd_data, rd_oe_n);
    chk_bit(rd_oe_n, 1'b1, "write-only read");
    chk_byte(low_port_o, 8'h5A, "no stray capture");
    motion_cpu_model_i.rd(TENSION_ADDR, rd_data, rd_oe_n);
    chk_byte(rd_data, 8'hC3, "tension reread");
    // Bus clock: period four, two high and two low
    for (int i = 0; i < 8; i++)
    begin
      motion_cpu_model_i.step(1);
      bc[i] = bus_clock_out_o;
    end
    for (int i = 0; i < 4; i++)
      chk_bit(bc[i+4], bc[i], "bus clock period");
    for (int i = 0; i < 6; i++)
      chk_bit(bc[i+2], ~bc[i], "bus clock phase");
    // Serial lines and motor link pass through
    {motion_txd_i, exec_txd_i, motor_sck_i, motor_mosi_i, motor_sel_n_i} = 7'h1E;
    motion_cpu_model_i.step(1);
    chk_bit(exec_rxd_o, 1'b1, "serial early");
    motion_cpu_model_i.step(3);
    chk_bit(exec_rxd_o, 1'b0, "exec rx");
    chk_bit(motion_rxd_o, 1'b0, "motion rx");
    chk_byte({5'h00, motor_sel_n_o}, 8'h06, "motor select");
    chk_bit(motor_sck_o & motor_mosi_o, 1'b1, "motor word");
    // Host command capture on the go strobe only
    host_cmd_i = 5'h15;
    motion_cpu_model_i.step(1);
    host_go_strobe_i = 1'b1;
    motion_cpu_model_i.step(2);
    host_cmd_i = 5'h0A;
    motion_cpu_model_i.step(3);
    chk_byte({3'h0, host_cmd_buf_o}, 8'h15, "host cmd");
    host_go_strobe_i = 1'b0;
    // Busy flop: set, clear, then both at once
    busy_set_i = 1'b1;
    motion_cpu_model_i.step(1);
    busy_set_i = 1'b0;
    motion_cpu_model_i.step(3);
    chk_bit(host_busy_flag_o, 1'b1, "busy set");
    busy_clr_i = 1'b1;
    motion_cpu_model_i.step(1);
    busy_clr_i = 1'b0;
    motion_cpu_model_i.step(3);
    chk_bit(host_busy_flag_o, 1'b0, "busy clear");
    {busy_set_i, busy_clr_i} = 2'h3;
    motion_cpu_model_i.step(1);
    {busy_set_i, busy_clr_i} = 2'h0;
    motion_cpu_model_i.step(3);
    chk_bit(host_busy_flag_o, 1'b1, "busy set wins");
    // Speed reached follows its source a few cycles on
    speed_ok_i = 1'b1;
    motion_cpu_model_i.step(4);
    chk_bit(speed_reached_o, 1'b1, "speed reached");
    // Reset in mid-run clears what was written
    motion_cpu_model_i.wr(OUT0_ADDR, 8'h5F);
    chk_byte(out_reg0_o, 8'h5F, "reg0 before reset");
    chk_bit(hub_lock_o, 1'b1, "hub before reset");
    sys_rst_i = 1'b1;
    motion_cpu_model_i.step(3);
    chk_reset();
    sys_rst_i = 1'b0;
    motion_cpu_model_i.step(3);
    final_report();
  end
endmodule : tb_top
